/* File: design/ipm_defs.vh */
// Contract
// RULE_01 - trap instruction is always taken, regardless of the global mask bit.
// RULE_02 - external vector taken only when request occurred and mask bit clear.
// RULE_03 - external interrupt requests wake the processor from halt.
// RULE_04 - each external group's sensitivity is chosen by a software setting.
// RULE_05 - edge requests are latched; latch clears when service routine is entered.
// RULE_06 - enabled pins of one group are NANDed before the detector.
// RULE_07 - a low enabled pin blocks the group request, even with rising edge.
// RULE_08 - peripheral flag interrupts only when mask clear and enable set, else pending.
// RULE_09 - peripheral request clears on write 0 or status access then associated access.
// RULE_10 - clear sequence resets the latch, discarding a pending, not-enabled request.
// RULE_11 - fixed descending vector map from the top of memory down.
// RULE_12 - only reset and the two external groups wake from halt.
// RULE_13 - after reset run mode with cpu clock at oscillator divided by 2.
// RULE_14 - slow enable bit plus two-bit select gives division by 4, 8, 16 or 32.
// RULE_15 - wait entered during slow mode gives slow-wait, keeping reduced rate.
// RULE_16 - wait stops cpu, peripherals run, mask bit forced to 0.
// RULE_17 - in wait any interrupt or reset wakes cpu toward its service routine.
// RULE_18 - halt stops oscillator and all internal and peripheral clocks.
// RULE_19 - on halt exit restart oscillator and wait 4096 cpu cycles before service; code waits 4096 oscillator cycles.
// RULE_20 - entering halt forces the mask bit to zero.
// RULE_21 - option bit decides halt/watchdog compatibility; else halt may cause reset.
// RULE_22 - condition codes pushed before service; mask set during it, cleared on restore; code restores the pushed mask value.
// RULE_23 - simultaneous enabled requests serviced in fixed hardware priority order.
// RULE_24 - on entry finish instruction, save registers, set mask, then fetch vector.
// RULE_25 - unused vector slots are never selected.
`ifndef IPM_DEFS_VH
`define IPM_DEFS_VH

// ************************************************************
// vector addresses, low byte of each pair
// ************************************************************
`define IPM_VEC_RESET     16'hfffe
`define IPM_VEC_TRAP      16'hfffc
`define IPM_VEC_EXT_A     16'hfffa
`define IPM_VEC_EXT_B     16'hfff8
`define IPM_VEC_CLK_GUARD 16'hfff6
`define IPM_VEC_SPI       16'hfff4
`define IPM_VEC_TIMER_A   16'hfff2
`define IPM_VEC_TIMER_B   16'hffee
`define IPM_VEC_I2C       16'hffe4

// ************************************************************
// peripheral source indices
// ************************************************************
`define IPM_NPER          4
`define IPM_PER_CLK_GUARD 0
`define IPM_PER_SPI       1
`define IPM_PER_TIMER_A   2
`define IPM_PER_TIMER_B   3

// ************************************************************
// sensitivity encodings (2 bits per external group)
// ************************************************************
`define IPM_SENS_FALL_LOW 2'h0
`define IPM_SENS_RISE     2'h1
`define IPM_SENS_FALL     2'h2
`define IPM_SENS_BOTH     2'h3

// ************************************************************
// clock dividers and timing
// ************************************************************
`define IPM_DIV_RUN       6'h02
`define IPM_DIV_SLOW0     6'h04
`define IPM_DIV_SLOW1     6'h08
`define IPM_DIV_SLOW2     6'h10
`define IPM_DIV_SLOW3     6'h20
`define IPM_HALT_WAKE_CYC 4096

// ************************************************************
// power states
// ************************************************************
`define IPM_PS_RUN        2'h0
`define IPM_PS_WAIT       2'h1
`define IPM_PS_HALT       2'h2
`define IPM_PS_WAKE       2'h3

`endif

/* File: design/ipm_ext_group.v */
`include "ipm_defs.vh"

// one external interrupt group: NAND combine, sync, detect, latch
module ipm_ext_group (
    // clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rst,
    input  wire       i_ce,
    // pins and configuration
    input  wire [7:0] i_pins,
    input  wire [7:0] i_pin_irq_en,
    input  wire [1:0] i_sens,
    input  wire       i_ack,
    // request
    output wire       o_req
);

    reg  [1:0] sync;
    reg        prev;
    reg        latch;
    reg  [1:0] sens_q;
    wire       level;
    wire       rise;
    wire       fall;
    wire       cfg_chg;

    // low pin with irq enabled forces combined level low, blocking rising edges
    wire       nand_in = ~(&(i_pins | ~i_pin_irq_en));         // see RULE_06 see RULE_07

    assign level   = sync[1];
    assign rise    = level & ~prev;
    assign fall    = ~level & prev;
    assign cfg_chg = (sens_q != i_sens);

    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sync   <= 2'h3;
            prev   <= 1'b1;
            latch  <= 1'b0;
            sens_q <= `IPM_SENS_FALL_LOW;
        end else if (i_ce) begin
            sync   <= {sync[0], ~nand_in};
            prev   <= level;
            sens_q <= i_sens;
            // edge capture wins over ack; sensitivity change discards pending
            if ((i_sens == `IPM_SENS_RISE && rise) ||
                ((i_sens == `IPM_SENS_FALL || i_sens == `IPM_SENS_FALL_LOW) && fall) ||
                (i_sens == `IPM_SENS_BOTH && (rise | fall)))
                latch <= 1'b1;                                 // see RULE_05 see RULE_04
            else if (i_ack || cfg_chg)
                latch <= 1'b0;                                 // see RULE_05
        end
    end

    // falling-edge-and-low mode: latched fall or present low level
    assign o_req = latch | (i_sens == `IPM_SENS_FALL_LOW && ~level);   // see RULE_04

endmodule // ipm_ext_group

/* File: design/ipm_clk_div.v */
`include "ipm_defs.vh"

// cpu clock enable generator: one pulse every div oscillator cycles
module ipm_clk_div (
    // clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rst,
    input  wire       i_ce,
    // control
    input  wire       i_run,
    input  wire [5:0] i_div,
    // tick
    output reg        o_tick
);

    reg [5:0] cnt;

    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt    <= 6'h00;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            if (!i_run) begin
                cnt    <= 6'h00;
                o_tick <= 1'b0;
            end else if (cnt >= i_div - 6'h01) begin
                cnt    <= 6'h00;
                o_tick <= 1'b1;
            end else begin
                cnt    <= cnt + 6'h01;
                o_tick <= 1'b0;
            end
        end
    end

endmodule // ipm_clk_div

/* File: design/ipm_ctrl.v */
`include "ipm_defs.vh"

module ipm_ctrl #(
    parameter HALT_WAKE_CYC = `IPM_HALT_WAKE_CYC
) (
    // clock, reset, enable
    input  wire                  i_sys_clk,
    input  wire                  i_rst,
    input  wire                  i_ce,
    // cpu instruction events (one cycle pulses)
    input  wire                  i_instr_done,
    input  wire                  i_trap_instr,
    input  wire                  i_wait_for_irq_instr,
    input  wire                  i_halt_instr,
    input  wire                  i_return_from_irq_instr,
    input  wire                  i_ack,
    // condition code mask bit from cpu (restored value on return)
    input  wire                  i_restored_mask,
    // external pins, group a and b
    input  wire [7:0]            i_ext_pins_a,
    input  wire [7:0]            i_ext_pins_b,
    input  wire [7:0]            i_ext_en_a,
    input  wire [7:0]            i_ext_en_b,
    // misc_control_reg fields
    input  wire [1:0]            i_sens_a,
    input  wire [1:0]            i_sens_b,
    input  wire                  i_slow_enable_bit,
    input  wire [1:0]            i_slow_divider_select,
    // peripheral flags and clear strobes
    input  wire [`IPM_NPER-1:0]  i_per_flag_set,
    input  wire [`IPM_NPER-1:0]  i_per_en,
    input  wire [`IPM_NPER-1:0]  i_per_wr_zero,
    input  wire [`IPM_NPER-1:0]  i_per_status_access,
    input  wire [`IPM_NPER-1:0]  i_per_assoc_access,
    input  wire                  i_i2c_req,
    // watchdog
    input  wire                  i_watchdog_halt_option,
    input  wire                  i_watchdog_enabled,
    // cpu side outputs
    output reg                   o_irq_take,
    output reg  [15:0]           o_vector,
    output reg                   o_save_ctx,
    output reg                   o_global_mask,
    output wire                  o_cpu_stall,
    output wire                  o_cpu_tick,
    output wire                  o_periph_tick,
    // oscillator and status
    output reg                   o_osc_enable,
    output reg                   o_watchdog_reset,
    output reg  [1:0]            o_power_state,
    output wire                  o_slow_active,
    output wire [`IPM_NPER-1:0]  o_per_pending
);

    // ************************************************************
    // functions
    // ************************************************************
    function [5:0] slow_div;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    slow_div = `IPM_DIV_SLOW0;
                2'h1:    slow_div = `IPM_DIV_SLOW1;
                2'h2:    slow_div = `IPM_DIV_SLOW2;
                default: slow_div = `IPM_DIV_SLOW3;
            endcase
        end
    endfunction

    // ************************************************************
    // external groups
    // ************************************************************
    wire ext_req_a;
    wire ext_req_b;
    reg  ack_ext_a;
    reg  ack_ext_b;
    reg  [7:0] pa_s1, pa_s2, pb_s1, pb_s2;

    // pins cross from outside; two flops before the group logic
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pa_s1 <= 8'hff;
            pa_s2 <= 8'hff;
            pb_s1 <= 8'hff;
            pb_s2 <= 8'hff;
        end else if (i_ce) begin
            pa_s1 <= i_ext_pins_a;
            pa_s2 <= pa_s1;
            pb_s1 <= i_ext_pins_b;
            pb_s2 <= pb_s1;
        end
    end

    // groups keep clocking in halt so a pin edge can start the wake-up
    ipm_ext_group u_grp_a (
        .i_sys_clk    (i_sys_clk),
        .i_rst        (i_rst),
        .i_ce         (i_ce),
        .i_pins       (pa_s2),
        .i_pin_irq_en (i_ext_en_a),
        .i_sens       (i_sens_a),
        .i_ack        (ack_ext_a),
        .o_req        (ext_req_a)
    );

    ipm_ext_group u_grp_b (
        .i_sys_clk    (i_sys_clk),
        .i_rst        (i_rst),
        .i_ce         (i_ce),
        .i_pins       (pb_s2),
        .i_pin_irq_en (i_ext_en_b),
        .i_sens       (i_sens_b),
        .i_ack        (ack_ext_b),
        .o_req        (ext_req_b)
    );

    // ************************************************************
    // peripheral pending latches
    // ************************************************************
    reg  [`IPM_NPER-1:0] per_pend;
    reg  [`IPM_NPER-1:0] status_seen;
    wire [`IPM_NPER-1:0] per_clear;

    assign per_clear = i_per_wr_zero | (status_seen & i_per_assoc_access);   // see RULE_09

    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            per_pend    <= {`IPM_NPER{1'b0}};
            status_seen <= {`IPM_NPER{1'b0}};
        end else if (i_ce && o_periph_tick) begin
            // new flag event wins over a clear in the same cycle
            per_pend    <= i_per_flag_set | (per_pend & ~per_clear);       // see RULE_10 see RULE_08
            status_seen <= (status_seen | (i_per_status_access & per_pend)) & ~per_clear;
        end
    end

    assign o_per_pending = per_pend;

    // ************************************************************
    // priority and vector select
    // ************************************************************
    wire [`IPM_NPER-1:0] per_act = per_pend & i_per_en;      // see RULE_08
    wire i2c_act = i_i2c_req;
    wire mask_req = ext_req_a | ext_req_b | (|per_act) | i2c_act;
    reg  trap_pend;
    reg  [15:0] next_vec;
    reg  [2:0]  next_src;

    // fixed order; unused slots have no source so never appear here
    always @* begin
        next_vec = `IPM_VEC_TRAP;
        next_src = 3'h0;
        if (trap_pend) begin
            next_vec = `IPM_VEC_TRAP;                          // see RULE_01
            next_src = 3'h1;
        end else if (!o_global_mask) begin                    // see RULE_02
            if (ext_req_a) begin
                next_vec = `IPM_VEC_EXT_A;                     // see RULE_23 see RULE_11
                next_src = 3'h2;
            end else if (ext_req_b) begin
                next_vec = `IPM_VEC_EXT_B;
                next_src = 3'h3;
            end else if (per_act[`IPM_PER_CLK_GUARD]) begin
                next_vec = `IPM_VEC_CLK_GUARD;
                next_src = 3'h4;
            end else if (per_act[`IPM_PER_SPI]) begin
                next_vec = `IPM_VEC_SPI;
                next_src = 3'h4;
            end else if (per_act[`IPM_PER_TIMER_A]) begin
                next_vec = `IPM_VEC_TIMER_A;
                next_src = 3'h4;
            end else if (per_act[`IPM_PER_TIMER_B]) begin
                next_vec = `IPM_VEC_TIMER_B;
                next_src = 3'h4;
            end else if (i2c_act) begin
                next_vec = `IPM_VEC_I2C;                       // see RULE_25
                next_src = 3'h4;
            end
        end
    end

    // ************************************************************
    // power mode state machine
    // ************************************************************
    localparam [12:0] WAKE_LAST = HALT_WAKE_CYC[12:0] - 13'h0001;
    reg  [12:0] wake_cnt;
    wire        wake_halt = ext_req_a | ext_req_b;           // see RULE_12 see RULE_03
    wire        in_run    = (o_power_state == `IPM_PS_RUN);
    wire [5:0]  cur_div   = i_slow_enable_bit ? slow_div(i_slow_divider_select)
                                              : `IPM_DIV_RUN;   // see RULE_13 see RULE_14
    wire        div_run   = (o_power_state != `IPM_PS_HALT);

    // slow-wait keeps cur_div while cpu is gated
    ipm_clk_div u_div (                                        // see RULE_15
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_run     (div_run),
        .i_div     (cur_div),
        .o_tick    (o_periph_tick)
    );

    assign o_cpu_tick    = o_periph_tick & in_run;           // see RULE_16 see RULE_18
    assign o_cpu_stall   = ~in_run;
    assign o_slow_active = i_slow_enable_bit;

    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_power_state    <= `IPM_PS_RUN;
            o_global_mask    <= 1'b1;
            o_osc_enable     <= 1'b1;
            o_irq_take       <= 1'b0;
            o_save_ctx       <= 1'b0;
            o_vector         <= `IPM_VEC_RESET;
            o_watchdog_reset <= 1'b0;
            trap_pend        <= 1'b0;
            ack_ext_a        <= 1'b0;
            ack_ext_b        <= 1'b0;
            wake_cnt         <= 13'h0000;
        end else if (i_ce) begin
            o_irq_take       <= 1'b0;
            o_save_ctx       <= 1'b0;
            o_watchdog_reset <= 1'b0;
            ack_ext_a        <= 1'b0;
            ack_ext_b        <= 1'b0;
            if (i_trap_instr)
                trap_pend <= 1'b1;                             // see RULE_01
            if (i_return_from_irq_instr) begin
                o_global_mask <= i_restored_mask;              // see RULE_22
            end
            case (o_power_state)
                `IPM_PS_RUN: begin
                    if (i_halt_instr) begin
                        o_global_mask <= 1'b0;                 // see RULE_20
                        if (i_watchdog_enabled && !i_watchdog_halt_option)
                            o_watchdog_reset <= 1'b1;          // see RULE_21
                        else begin
                            o_power_state <= `IPM_PS_HALT;
                            o_osc_enable  <= 1'b0;             // see RULE_18
                        end
                    end else if (i_wait_for_irq_instr) begin
                        o_global_mask <= 1'b0;                 // see RULE_16
                        o_power_state <= `IPM_PS_WAIT;
                    end else if (i_instr_done && next_src != 3'h0 && !o_irq_take) begin
                        // take at instruction boundary: save, set mask, vector
                        o_irq_take    <= 1'b1;                 // see RULE_24
                        o_save_ctx    <= 1'b1;                 // see RULE_22
                        o_vector      <= next_vec;
                        o_global_mask <= 1'b1;
                        if (next_src == 3'h1 && !i_trap_instr)
                            trap_pend <= 1'b0;
                        ack_ext_a <= (next_src == 3'h2);       // see RULE_05
                        ack_ext_b <= (next_src == 3'h3);
                    end
                end
                `IPM_PS_WAIT: begin
                    if (mask_req)
                        o_power_state <= `IPM_PS_RUN;          // see RULE_17
                end
                `IPM_PS_HALT: begin
                    if (wake_halt) begin
                        o_osc_enable  <= 1'b1;                 // see RULE_19
                        wake_cnt      <= 13'h0000;
                        o_power_state <= `IPM_PS_WAKE;
                    end
                end
                `IPM_PS_WAKE: begin
                    // oscillator settle before the cpu resumes
                    if (wake_cnt == WAKE_LAST)
                        o_power_state <= `IPM_PS_RUN;          // see RULE_19
                    else
                        wake_cnt <= wake_cnt + 13'h0001;
                end
                default: o_power_state <= `IPM_PS_RUN;
            endcase
        end
    end

endmodule // ipm_ctrl

/* File: dv/ipm_cpu_model.sv */
// ************************************************************
// cpu core model: one instruction per cycle, fixed-length handler
// ************************************************************
module ipm_cpu_model (
    input  logic        i_sys_clk,
    input  logic        i_rst,
    input  logic        i_irq_take,
    input  logic [15:0] i_vector,
    input  logic        i_global_mask,
    input  logic        i_cpu_stall,
    output logic        o_instr_done,
    output logic        o_ret,
    output logic        o_restored_mask
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] last_vec;
    integer      takes;
    logic        prev_mask;
    logic [3:0]  cnt;
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            last_vec <= 16'h0000;
            takes <= 0;
            prev_mask <= 1'b1;
            cnt <= 4'h0;
            o_instr_done <= 1'b0;
            o_ret <= 1'b0;
            o_restored_mask <= 1'b1;
        end else begin
            prev_mask <= i_global_mask;
            o_instr_done <= !i_cpu_stall;
            o_ret <= (cnt == 4'h1);
            if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
            if (i_irq_take) begin
                cnt <= 4'h6;
                takes <= takes + 1;
                last_vec <= i_vector;
                // handler pops the mask value pushed on entry
                o_restored_mask <= prev_mask;
            end
        end
    end
endmodule // ipm_cpu_model

/* File: dv/ipm_ctrl_sva.sv */
// ************************************************************
// port checker for the interrupt and power controller
// ************************************************************
module ipm_ctrl_chk #(
    parameter HALT_WAKE_CYC = 8
) (
    input logic        i_sys_clk,
    input logic        i_rst,
    input logic        i_ce,
    input logic        i_instr_done,
    input logic        i_trap_instr,
    input logic        i_wait_for_irq_instr,
    input logic        i_halt_instr,
    input logic        i_slow_enable_bit,
    input logic        i_watchdog_halt_option,
    input logic        i_watchdog_enabled,
    input logic        o_irq_take,
    input logic [15:0] o_vector,
    input logic        o_save_ctx,
    input logic        o_global_mask,
    input logic        o_osc_enable,
    input logic        o_watchdog_reset,
    input logic [1:0]  o_power_state,
    input logic        o_slow_active,
    input logic        o_periph_tick
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [15:0] wcnt;
    // cycles spent in the restart state
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            wcnt <= 16'h0000;
        else
            wcnt <= (o_power_state == 2'h3) ? wcnt + 16'h0001 : 16'h0000;
    end
    a_trap_taken: assert property ((i_ce && i_trap_instr && i_instr_done && o_power_state == 2'h0 && !o_irq_take)
        |-> ##[2:4] (o_irq_take && o_vector == 16'hfffc)) else $error("trap not serviced");
    a_take_unmasked: assert property ((o_irq_take && o_vector != 16'hfffc) |-> !$past(o_global_mask))
        else $error("taken while masked");
    a_take_context: assert property (o_irq_take |-> (o_save_ctx && o_global_mask))
        else $error("no save or mask on entry");
    a_vector_legal: assert property (o_irq_take |-> o_vector inside {16'hfffc, 16'hfffa, 16'hfff8,
        16'hfff6, 16'hfff4, 16'hfff2, 16'hffee, 16'hffe4}) else $error("illegal vector");
    a_wait_mask: assert property ((i_ce && i_wait_for_irq_instr && o_power_state == 2'h0 && !o_irq_take)
        |=> (o_power_state == 2'h1 && !o_global_mask)) else $error("wait entry wrong");
    a_halt_osc_off: assert property (o_power_state == 2'h2 |-> !o_osc_enable)
        else $error("oscillator on in halt");
    a_halt_mask: assert property ($rose(o_power_state == 2'h2) |-> !o_global_mask)
        else $error("mask set on halt entry");
    a_wdg_refuse: assert property ((i_ce && i_halt_instr && i_watchdog_enabled && !i_watchdog_halt_option
        && o_power_state == 2'h0) |=> (o_watchdog_reset && o_power_state != 2'h2)) else $error("halt not refused");
    a_take_in_run: assert property (o_irq_take |-> $past(o_power_state) == 2'h0)
        else $error("take outside run");
    a_wake_delay: assert property ((o_power_state == 2'h0 && $past(o_power_state) == 2'h3)
        |-> wcnt >= HALT_WAKE_CYC - 1) else $error("restart delay too short");
    a_wake_bound: assert property (wcnt <= HALT_WAKE_CYC + 4)
        else $error("restart delay too long");
    a_slow_flag: assert property (o_slow_active == i_slow_enable_bit)
        else $error("slow status wrong");
    a_run_tick: assert property ((!i_slow_enable_bit && $stable(i_slow_enable_bit) && !o_power_state[1]
        && o_periph_tick) |=> !o_periph_tick ##1 (o_periph_tick || i_slow_enable_bit || o_power_state[1]))
        else $error("run tick rate wrong");
endmodule // ipm_ctrl_chk
bind ipm_ctrl ipm_ctrl_chk #(.HALT_WAKE_CYC(HALT_WAKE_CYC)) chk_u (.*);

/* File: dv/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, trap, wait_for_irq_instr, halt, wen, wopt, slow, i2c;
    logic [7:0]  pa, pb, ea, eb;
    logic [1:0]  sa, sb, sel;
    logic [3:0]  pset, pen, pwz, pst, pas;
    wire         take, save, mask, stall, ctick, ptick, osc, wrst, slowa, done, ret, rmask;
    wire  [15:0] vec;
    wire  [1:0]  ps;
    wire  [3:0]  pend;
    integer      fails, checked, base, i;
    ipm_ctrl #(.HALT_WAKE_CYC(8)) dut_u (.i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_instr_done(done),
        .i_trap_instr(trap), .i_wait_for_irq_instr(wait_for_irq_instr), .i_halt_instr(halt), .i_return_from_irq_instr(ret),
        .i_ack(1'b0), .i_restored_mask(rmask), .i_ext_pins_a(pa), .i_ext_pins_b(pb), .i_ext_en_a(ea),
        .i_ext_en_b(eb), .i_sens_a(sa), .i_sens_b(sb), .i_slow_enable_bit(slow), .i_slow_divider_select(sel),
        .i_per_flag_set(pset), .i_per_en(pen), .i_per_wr_zero(pwz), .i_per_status_access(pst),
        .i_per_assoc_access(pas), .i_i2c_req(i2c), .i_watchdog_halt_option(wopt), .i_watchdog_enabled(wen),
        .o_irq_take(take), .o_vector(vec), .o_save_ctx(save), .o_global_mask(mask), .o_cpu_stall(stall),
        .o_cpu_tick(ctick), .o_periph_tick(ptick), .o_osc_enable(osc), .o_watchdog_reset(wrst),
        .o_power_state(ps), .o_slow_active(slowa), .o_per_pending(pend));
    ipm_cpu_model cpu_u (.i_sys_clk(clk), .i_rst(rst), .i_irq_take(take), .i_vector(vec), .i_global_mask(mask),
        .i_cpu_stall(stall), .o_instr_done(done), .o_ret(ret), .o_restored_mask(rmask));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task smp(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task tick_rate(input integer exp);
        integer c;
        c = 0;
        smp(64);
        repeat (64) begin
            @(negedge clk);
            c = c + ptick + ctick;
        end
        chk(c, exp);
    endtask
    task take_is(input logic [15:0] v);
        for (i = 0; i < 40 && cpu_u.takes == base; i++)
            @(negedge clk);
        chk(cpu_u.takes - base, 1);
        chk(cpu_u.last_vec, v);
        base = cpu_u.takes;
    endtask
    task no_take(input integer n);
        smp(n);
        chk(cpu_u.takes - base, 0);
    endtask
    // held over two edges so the divide-by-2 peripheral tick sees it once
    task per(input integer k, input logic [3:0] b);
        @(posedge clk) {pset, pwz, pst, pas} <= {b, 12'h000} >> (4 * k);
        @(posedge clk);
        @(posedge clk) {pset, pwz, pst, pas} <= 16'h0000;
    endtask
    task pulse(input integer k);
        @(posedge clk) {trap, wait_for_irq_instr, halt} <= 3'h4 >> k;
        @(posedge clk) {trap, wait_for_irq_instr, halt} <= 3'h0;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #(20000 * 100);
        fails = fails + 1;
        print_verdict;
    end
    initial begin
        {rst, fails, checked} = {1'b1, 32'd0, 32'd0};
        {trap, wait_for_irq_instr, halt, wen, wopt, slow, i2c} = 7'h00;
        {pa, pb, ea, eb, sa, sb, sel} = {8'hff, 8'hff, 8'h01, 8'h03, 2'h2, 2'h1, 2'h0};
        {pset, pen, pwz, pst, pas} = 20'h00000;
        repeat (5) @(posedge clk);
        @(posedge clk) rst <= 1'b0;
        smp(1);
        base = cpu_u.takes;
        chk(vec, 16'hfffe);
        chk({mask, osc, ps}, 4'hc);
        tick_rate(64);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) {slow, sel} <= {1'b1, k[1:0]};
            tick_rate(64 >> (k + 1));
        end
        @(posedge clk) slow <= 1'b0;
        pulse(0);
        take_is(16'hfffc);
        smp(10);
        chk(mask, 1'b1);
        @(posedge clk) pa <= 8'hfe;
        no_take(20);
        pulse(1);
        take_is(16'hfffa);
        smp(10);
        chk(mask, 1'b0);
        no_take(20);
        @(posedge clk) pa <= 8'hff;
        per(0, 4'h4);
        no_take(10);
        chk(pend, 4'h4);
        per(2, 4'h4);
        per(3, 4'h4);
        smp(2);
        chk(pend, 4'h0);
        @(posedge clk) pen <= 4'h6;
        no_take(10);
        per(0, 4'h2);
        take_is(16'hfff4);
        per(1, 4'h2);
        no_take(12);
        @(posedge clk) pb <= 8'hfd;
        @(posedge clk) pb <= 8'hfc;
        @(posedge clk) pb <= 8'hfd;
        no_take(10);
        @(posedge clk) pb <= 8'hff;
        take_is(16'hfff8);
        smp(10);
        @(posedge clk) pb <= 8'hfb;
        @(posedge clk) pb <= 8'hff;
        no_take(10);
        @(posedge clk) wen <= 1'b1;
        pulse(2);
        smp(1);
        chk({wrst, ps}, 3'h4);
        @(posedge clk) wopt <= 1'b1;
        pulse(2);
        smp(2);
        chk({osc, mask, ps}, 4'h2);
        @(posedge clk) i2c <= 1'b1;
        no_take(30);
        chk(ps, 2'h2);
        @(posedge clk) pa <= 8'hfe;
        for (i = 0; i < 20 && ps === 2'h2; i++)
            @(negedge clk);
        chk({osc, ps}, 3'h7);
        take_is(16'hfffa);
        take_is(16'hffe4);
        @(posedge clk) {i2c, pa, slow, sel} <= {1'b0, 8'hff, 1'b1, 2'h0};
        smp(10);
        pulse(1);
        smp(2);
        chk({slowa, ps}, 3'h5);
        tick_rate(16);
        @(posedge clk) i2c <= 1'b1;
        take_is(16'hffe4);
        @(posedge clk) i2c <= 1'b0;
        smp(10);
        print_verdict;
    end
endmodule // tb
